// ==== clmp_defs.vh ====
// Constants for the chip link message pipe
`ifndef CLMP_DEFS_VH
`define CLMP_DEFS_VH
// ----------------------------------------
// Widths
// ----------------------------------------
`define CLMP_WORD_W 32
`define CLMP_LEN_W 10
`define CLMP_MAX_PAYLOAD 10'h0_3FC
`define CLMP_MAX_MSG 10'h0_200
// ----------------------------------------
// Header field positions (first header word)
// ----------------------------------------
`define CLMP_TYPE_LSB 28
`define CLMP_TYPE_MSB 31
`define CLMP_SIZE_LSB 0
`define CLMP_SIZE_MSB 9
`define CLMP_DEV_LSB 16
`define CLMP_DEV_MSB 19
`define CLMP_PORT_LSB 20
`define CLMP_PORT_MSB 24
// ----------------------------------------
// Header length by type
// ----------------------------------------
`define CLMP_HDR_MIN 3'h2
`define CLMP_HDR_MAX 3'h4
// ----------------------------------------
// Receive queue
// ----------------------------------------
`define CLMP_RXQ_AW 11
`define CLMP_RXQ_DEPTH 2048
// ----------------------------------------
// Link clock divider: 50 MHz / 2 per half period
// ----------------------------------------
`define CLMP_CLK_DIV 2'h1
`endif

// ==== clmp_pipe.v ====
// Chip link message pipe: source end and target end of one device
// Operation
// - 32-bit word plus clock, strobe, permit
// - Independent transmit and receive pipes
// - Source drives data; target drives permit
// - Source forwards clock; target uses it
// - Target captures on forwarded clock fall
// - Strobe frames whole message, finds boundaries
// - Strobe rises with first word
// - Strobe falls at last word start
// - Back-to-back messages accepted without gaps
// - Permit low when no room for message
// - Source waits to start a message while permit is low
// - Header words precede payload words
// - Header carries size, type, device, port
// - Header length two to four, by type
`timescale 1ns/100ps
`include "clmp_defs.vh"
module clmp_pipe #(
  parameter TYPE_LSB = `CLMP_TYPE_LSB,
  parameter TYPE_MSB = `CLMP_TYPE_MSB,
  parameter SIZE_LSB = `CLMP_SIZE_LSB,
  parameter SIZE_MSB = `CLMP_SIZE_MSB,
  parameter DEV_LSB = `CLMP_DEV_LSB,
  parameter DEV_MSB = `CLMP_DEV_MSB,
  parameter PORT_LSB = `CLMP_PORT_LSB,
  parameter PORT_MSB = `CLMP_PORT_MSB
) (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // User transmit request
  input wire i_tx_start,
  input wire [3:0] i_tx_type,
  input wire [3:0] i_tx_dev,
  input wire [4:0] i_tx_port,
  input wire [9:0] i_tx_size,
  input wire [31:0] i_tx_hdr_extra,
  input wire [31:0] i_tx_payload,
  output reg o_tx_busy,
  output reg o_tx_payload_take,
  // Link transmit side
  output reg [31:0] o_link_tx_word,
  output reg o_link_tx_fwd_clock,
  output reg o_link_tx_msg_strobe,
  input wire i_link_tx_permit_in,
  // Link receive side
  input wire [31:0] i_link_rx_word,
  input wire i_link_rx_fwd_clock,
  input wire i_link_rx_msg_strobe,
  output reg o_link_rx_permit_out,
  // User receive side
  input wire i_rx_ready,
  output reg o_rx_valid,
  output reg [31:0] o_rx_word,
  output reg o_rx_first,
  output reg o_rx_last,
  output reg [2:0] o_rx_hdr_len
);

  // ----------------------------------------
  // Header length by type
  // ----------------------------------------
  function [2:0] hdr_len;
    input [3:0] t;
    begin
      if (t[1:0] == 2'h0) begin
        hdr_len = `CLMP_HDR_MIN;
      end else if (t[1:0] == 2'h3) begin
        hdr_len = `CLMP_HDR_MAX;
      end else begin
        hdr_len = 3'h3;
      end
    end
  endfunction

  // ----------------------------------------
  // Transmit clock divider
  // ----------------------------------------
  reg [1:0] div_cnt;
  reg tx_tick;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      div_cnt <= 2'h0;
      o_link_tx_fwd_clock <= 1'b0;
      tx_tick <= 1'b0;
    end else begin
      tx_tick <= 1'b0;
      if (div_cnt == `CLMP_CLK_DIV) begin
        div_cnt <= 2'h0;
        o_link_tx_fwd_clock <= ~o_link_tx_fwd_clock;
        tx_tick <= ~o_link_tx_fwd_clock;
      end else begin
        div_cnt <= div_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Source end
  // ----------------------------------------
  localparam TX_IDLE = 2'h0;
  localparam TX_HDR = 2'h1;
  localparam TX_PAY = 2'h2;
  reg [1:0] tx_state;
  reg [2:0] tx_hlen;
  reg [2:0] tx_hidx;
  reg [9:0] tx_left;
  reg [3:0] tx_type;
  reg [3:0] tx_dev;
  reg [4:0] tx_port;
  reg [9:0] tx_size;
  reg [31:0] tx_extra;
  reg [1:0] permit_sync;
  reg tx_pend;
  reg [31:0] hdr0;
  wire tx_last_hdr = (tx_hidx + 3'h1 == tx_hlen);

  always @* begin
    hdr0 = 32'h0000_0000;
    hdr0[TYPE_MSB:TYPE_LSB] = tx_type;
    hdr0[SIZE_MSB:SIZE_LSB] = tx_size;
    hdr0[DEV_MSB:DEV_LSB] = tx_dev;
    hdr0[PORT_MSB:PORT_LSB] = tx_port;
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      permit_sync <= 2'h0;
    end else begin
      permit_sync <= {permit_sync[0], i_link_tx_permit_in};
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tx_state <= TX_IDLE;
      tx_hlen <= 3'h0;
      tx_hidx <= 3'h0;
      tx_left <= 10'h000;
      tx_type <= 4'h0;
      tx_dev <= 4'h0;
      tx_port <= 5'h00;
      tx_size <= 10'h000;
      tx_extra <= 32'h0000_0000;
      tx_pend <= 1'b0;
      o_tx_busy <= 1'b0;
      o_tx_payload_take <= 1'b0;
      o_link_tx_word <= 32'h0000_0000;
      o_link_tx_msg_strobe <= 1'b0;
    end else begin
      o_tx_payload_take <= 1'b0;
      if (i_tx_start && !o_tx_busy) begin
        tx_pend <= 1'b1;
        o_tx_busy <= 1'b1;
        tx_type <= i_tx_type;
        tx_dev <= i_tx_dev;
        tx_port <= i_tx_port;
        tx_size <= (i_tx_size > `CLMP_MAX_PAYLOAD) ? `CLMP_MAX_PAYLOAD : i_tx_size;
        tx_extra <= i_tx_hdr_extra;
      end
      // Words change one cycle after the forwarded clock rises
      if (tx_tick) begin
        case (tx_state)
          TX_IDLE: begin
            o_link_tx_msg_strobe <= 1'b0;
            if (tx_pend && permit_sync[1]) begin
              tx_pend <= 1'b0;
              tx_hlen <= hdr_len(tx_type);
              tx_hidx <= 3'h1;
              tx_left <= tx_size;
              o_link_tx_word <= hdr0;
              o_link_tx_msg_strobe <= 1'b1;
              tx_state <= TX_HDR;
            end
          end
          TX_HDR: begin
            o_link_tx_word <= tx_extra ^ {29'h0000_0000, tx_hidx};
            tx_hidx <= tx_hidx + 3'h1;
            if (tx_last_hdr) begin
              if (tx_left == 10'h000) begin
                o_link_tx_msg_strobe <= 1'b0;
                o_tx_busy <= 1'b0;
                tx_state <= TX_IDLE;
              end else begin
                tx_state <= TX_PAY;
              end
            end
          end
          TX_PAY: begin
            o_link_tx_word <= i_tx_payload;
            o_tx_payload_take <= 1'b1;
            tx_left <= tx_left - 10'h001;
            if (tx_left == 10'h001) begin
              o_link_tx_msg_strobe <= 1'b0;
              o_tx_busy <= 1'b0;
              tx_state <= TX_IDLE;
            end
          end
          default: begin
            tx_state <= TX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Target end: synchronise and capture
  // ----------------------------------------
  reg [2:0] rclk_sync;
  reg [31:0] rword_s1;
  reg [31:0] rword_s2;
  reg [1:0] rstb_s;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rclk_sync <= 3'h0;
      rword_s1 <= 32'h0000_0000;
      rword_s2 <= 32'h0000_0000;
      rstb_s <= 2'h0;
    end else begin
      rclk_sync <= {rclk_sync[1:0], i_link_rx_fwd_clock};
      rword_s1 <= i_link_rx_word;
      rword_s2 <= rword_s1;
      rstb_s <= {rstb_s[0], i_link_rx_msg_strobe};
    end
  end
  wire rx_fall = rclk_sync[2] & ~rclk_sync[1];

  // ----------------------------------------
  // Receive framing and queue
  // ----------------------------------------
  reg [33:0] rxq [0:`CLMP_RXQ_DEPTH-1];
  reg [`CLMP_RXQ_AW:0] wr_ptr;
  reg [`CLMP_RXQ_AW:0] rd_ptr;
  reg prev_stb;
  reg [2:0] rx_hidx;
  reg [33:0] rd_data;
  wire [`CLMP_RXQ_AW:0] used = wr_ptr - rd_ptr;
  wire in_msg = prev_stb;
  wire stb_now = rstb_s[1];
  // A word is part of a message when strobe is high or just fell
  wire rx_take = rx_fall && (stb_now || in_msg);
  wire rx_first = stb_now && !in_msg;
  wire rx_last = !stb_now && in_msg;
  wire q_empty = (used == 12'h000);
  wire q_pop = !q_empty && (!o_rx_valid || i_rx_ready);

  always @(posedge i_clk_sys) begin
    if (rx_take) begin
      rxq[wr_ptr[`CLMP_RXQ_AW-1:0]] <= {rx_first, rx_last, rword_s2};
    end
    rd_data <= rxq[rd_ptr[`CLMP_RXQ_AW-1:0]];
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_ptr <= 12'h000;
      prev_stb <= 1'b0;
      rx_hidx <= 3'h0;
      o_link_rx_permit_out <= 1'b0;
    end else begin
      if (rx_fall) begin
        prev_stb <= stb_now;
      end
      if (rx_take) begin
        wr_ptr <= wr_ptr + 12'h001;
      end
      // Room for one full message, counting eight words in flight
      o_link_rx_permit_out <= (used < (12'h800 - {2'h0, `CLMP_MAX_MSG}) - 12'h008);
    end
  end

  // ----------------------------------------
  // Receive drain toward user
  // ----------------------------------------
  reg pop_d;
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_ptr <= 12'h000;
      pop_d <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_word <= 32'h0000_0000;
      o_rx_first <= 1'b0;
      o_rx_last <= 1'b0;
      o_rx_hdr_len <= 3'h0;
    end else begin
      pop_d <= 1'b0;
      if (o_rx_valid && i_rx_ready) begin
        o_rx_valid <= 1'b0;
      end
      if (q_pop && !pop_d) begin
        rd_ptr <= rd_ptr + 12'h001;
        pop_d <= 1'b1;
      end
      if (pop_d) begin
        o_rx_valid <= 1'b1;
        o_rx_word <= rd_data[31:0];
        o_rx_first <= rd_data[33];
        o_rx_last <= rd_data[32];
        if (rd_data[33]) begin
          o_rx_hdr_len <= hdr_len(rd_data[TYPE_MSB:TYPE_LSB]);
        end
      end
    end
  end

endmodule // clmp_pipe

// ==== clmp_monitor.sv ====
// Port checker for the chip link message pipe
`timescale 1ns/100ps
module clmp_monitor (
  // Clock, reset and user side
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_tx_start,
  input wire o_tx_busy,
  input wire i_rx_ready,
  input wire o_rx_valid,
  input wire [31:0] o_rx_word,
  input wire o_rx_first,
  input wire [2:0] o_rx_hdr_len,
  // Link transmit side
  input wire [31:0] o_link_tx_word,
  input wire o_link_tx_fwd_clock,
  input wire o_link_tx_msg_strobe
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_take; i_tx_start && !o_tx_busy; endsequence
  sequence s_tick;
    o_link_tx_fwd_clock && $past(o_link_tx_fwd_clock) && !$past(o_link_tx_fwd_clock, 2);
  endsequence
  start_busy_a: assert property (s_take |=> o_tx_busy) else $error("no busy");
  idle_strobe_a: assert property (!o_tx_busy |-> !o_link_tx_msg_strobe)
    else $error("strobe idle");
  word_tick_a: assert property ($changed(o_link_tx_word) |-> s_tick)
    else $error("word skew");
  strobe_tick_a: assert property ($changed(o_link_tx_msg_strobe) |-> s_tick)
    else $error("strobe skew");
  clock_rate_a: assert property ($changed(o_link_tx_fwd_clock) |=> $stable(o_link_tx_fwd_clock))
    else $error("clock rate");
  strobe_start_a: assert property ($rose(o_link_tx_msg_strobe) |-> o_tx_busy)
    else $error("strobe start");
  valid_hold_a: assert property (o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_word))
    else $error("valid drop");
  hdr_len_a: assert property (o_rx_valid && o_rx_first |-> o_rx_hdr_len inside {[2:4]})
    else $error("hdr len");
endmodule // clmp_monitor

// ==== clmp_peer.sv ====
// Model of the peer device's link port
`timescale 1ns/100ps
module clmp_peer (
  // Link from the block, and the permit level set by the bench
  input wire [31:0] i_word,
  input wire i_clk,
  input wire i_strobe,
  input wire i_permit,
  input wire i_rx_permit,
  // Link toward the block
  output wire o_permit,
  output reg [31:0] o_word = 32'h0000_0000,
  output reg o_clk = 1'b0,
  output reg o_strobe = 1'b0,
  // Captured words
  output reg [32:0] o_cap = 33'h0_0000_0000,
  output reg o_cap_tgl = 1'b0
);
  reg was = 1'b0;
  assign o_permit = i_permit;
  always @(negedge i_clk) begin
    if (i_strobe || was) begin
      o_cap <= {!i_strobe, i_word};
      o_cap_tgl <= !o_cap_tgl;
    end
    was <= i_strobe;
  end
  task send(input int n, input [31:0] b);
    wait (i_rx_permit);
    for (int k = 0; k < n; k++) begin
      o_clk = 1'b1;
      o_word = b + k;
      o_strobe = k < n - 1;
      #80 o_clk = 1'b0;
      #80;
    end
  endtask
  task idle;
    o_word = ~o_word;
    #160;
  endtask
endmodule // clmp_peer

// ==== testbench.sv ====
// Self-checking bench for the chip link message pipe
`timescale 1ns/100ps
`define CHK(g, e) chk(g, e)
module testbench;
  reg i_clk_sys = 1'b0;
  reg i_rst_n = 1'b0;
  reg i_tx_start = 1'b0;
  reg [3:0] i_tx_type = 4'h0;
  reg [3:0] i_tx_dev = 4'h0;
  reg [4:0] i_tx_port = 5'h00;
  reg [9:0] i_tx_size = 10'h001;
  reg [31:0] i_tx_hdr_extra = 32'h0000_0000;
  reg [31:0] i_tx_payload = 32'h0000_0000;
  reg i_rx_ready = 1'b0;
  reg permit = 1'b1;
  reg hold = 1'b0;
  reg [31:0] pexp;
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  wire o_tx_busy, o_tx_payload_take, o_link_tx_fwd_clock, o_link_tx_msg_strobe;
  wire i_link_tx_permit_in, i_link_rx_fwd_clock, i_link_rx_msg_strobe, o_link_rx_permit_out;
  wire o_rx_valid, o_rx_first, o_rx_last, tgl;
  wire [31:0] o_link_tx_word, i_link_rx_word, o_rx_word;
  wire [2:0] o_rx_hdr_len;
  wire [32:0] cap;
  logic [32:0] txq[$];
  logic [36:0] rxq[$];
  clmp_pipe uut (.i_clk_sys, .i_rst_n, .i_tx_start, .i_tx_type, .i_tx_dev, .i_tx_port,
    .i_tx_size, .i_tx_hdr_extra, .i_tx_payload, .o_tx_busy, .o_tx_payload_take,
    .o_link_tx_word, .o_link_tx_fwd_clock, .o_link_tx_msg_strobe, .i_link_tx_permit_in,
    .i_link_rx_word, .i_link_rx_fwd_clock, .i_link_rx_msg_strobe, .o_link_rx_permit_out,
    .i_rx_ready, .o_rx_valid, .o_rx_word, .o_rx_first, .o_rx_last, .o_rx_hdr_len);
  clmp_peer peer (.i_word(o_link_tx_word), .i_clk(o_link_tx_fwd_clock),
    .i_strobe(o_link_tx_msg_strobe), .i_permit(permit), .i_rx_permit(o_link_rx_permit_out),
    .o_permit(i_link_tx_permit_in), .o_word(i_link_rx_word), .o_clk(i_link_rx_fwd_clock),
    .o_strobe(i_link_rx_msg_strobe), .o_cap(cap), .o_cap_tgl(tgl));
  initial forever #10 i_clk_sys = ~i_clk_sys;
  task chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  always @(posedge i_clk_sys) begin
    #1;
    if (o_tx_payload_take) i_tx_payload = i_tx_payload + 32'h0000_0001;
    i_rx_ready = !hold && $urandom_range(1);
  end
  always @(tgl) if (i_rst_n) `CHK(cap, txq.pop_front());
  always @(posedge i_clk_sys) if (o_rx_valid && i_rx_ready)
    `CHK({o_rx_first, o_rx_last, o_rx_word, o_rx_first ? o_rx_hdr_len : 3'h0}, rxq.pop_front());
  task tx_msg(input [3:0] t, input [9:0] s);
    int h;
    h = t[1:0] == 2'b00 ? 2 : t[1:0] == 2'b11 ? 4 : 3;
    i_tx_type = t;
    i_tx_size = s;
    i_tx_dev = $urandom;
    i_tx_port = $urandom;
    i_tx_hdr_extra = $urandom;
    txq.push_back({1'b0, t, 3'h0, i_tx_port, i_tx_dev, 6'h00, s});
    for (int k = 1; k < h; k++) txq.push_back({1'b0, i_tx_hdr_extra ^ k});
    for (int j = 0; j < s; j++) txq.push_back({j == s - 1, pexp + j});
    pexp = pexp + s;
    for (int i = 0; i < 400 && o_tx_busy; i++) @(posedge i_clk_sys) #1;
    i_tx_start = 1'b1;
    @(posedge i_clk_sys) #1;
    i_tx_start = 1'b0;
  endtask
  task rx_msg(input int n);
    logic [31:0] b;
    int h;
    b = $urandom;
    h = b[29:28] == 2'b00 ? 2 : b[29:28] == 2'b11 ? 4 : 3;
    for (int k = 0; k < n; k++) rxq.push_back({k == 0, k == n - 1, b + k, k ? 3'h0 : h[2:0]});
    peer.send(n, b);
  endtask
  task drain;
    for (int i = 0; i < 30000 && (txq.size() || rxq.size() || o_tx_busy); i++)
      @(posedge i_clk_sys) #1;
    `CHK(txq.size() + rxq.size(), 0);
  endtask
  initial begin
    void'($urandom(25381));
    i_tx_payload = $urandom;
    pexp = i_tx_payload;
    repeat (8) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    repeat (2) @(posedge i_clk_sys) #1;
    `CHK(o_link_rx_permit_out, 1'b1);
    fork
      for (int t = 0; t < 16; t++) tx_msg(t[3:0], $urandom_range(3, 1));
      for (int n = 2; n < 6; n++) rx_msg(n);
    join
    peer.idle();
    drain();
    $display("duplex done");
    permit = 1'b0;
    repeat (4) @(posedge i_clk_sys) #1;
    tx_msg(4'h3, 10'h002);
    repeat (40) @(posedge i_clk_sys) #1;
    `CHK(txq.size(), 6);
    permit = 1'b1;
    drain();
    $display("permit done");
    hold = 1'b1;
    repeat (3) rx_msg(512);
    peer.idle();
    repeat (8) @(posedge i_clk_sys) #1;
    `CHK(o_link_rx_permit_out, 1'b0);
    hold = 1'b0;
    drain();
    `CHK(o_link_rx_permit_out, 1'b1);
    $display("fill done");
    end_sim();
  end
endmodule // testbench
bind clmp_pipe clmp_monitor mon (.i_clk_sys, .i_rst_n, .i_tx_start, .o_tx_busy, .i_rx_ready,
  .o_rx_valid, .o_rx_word, .o_rx_first, .o_rx_hdr_len, .o_link_tx_word,
  .o_link_tx_fwd_clock, .o_link_tx_msg_strobe);
